// ---- hdl/dtc_cfg.svh ----
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Oscillator periods per machine cycle, phase index = (state-1)*2+(phase-1)
`define DTC_MC_PERIODS 12
`define DTC_PH_LAST 4'hb
`define DTC_PH_S3P1 4'h4
`define DTC_PH_S5P2 4'h9

// Register byte offsets
`define DTC_OFF_MODE 8'h00
`define DTC_OFF_CTRL 8'h04
`define DTC_OFF_T0LO 8'h08
`define DTC_OFF_T0HI 8'h0c
`define DTC_OFF_T1LO 8'h10
`define DTC_OFF_T1HI 8'h14

// Mode register fields
`define DTC_TIMER_MODE_REGISTER_MD0_LSB 0
`define DTC_TIMER_MODE_REGISTER_CT0 2
`define DTC_TIMER_MODE_REGISTER_GATE0 3
`define DTC_TIMER_MODE_REGISTER_MD1_LSB 4
`define DTC_TIMER_MODE_REGISTER_CT1 6
`define DTC_TIMER_MODE_REGISTER_GATE1 7

// Control register fields
`define DTC_TIMER_CONTROL_REGISTER_TR0 4
`define DTC_TIMER_CONTROL_REGISTER_TF0 5
`define DTC_TIMER_CONTROL_REGISTER_TR1 6
`define DTC_TIMER_CONTROL_REGISTER_TF1 7

// Reset values
`define DTC_RST_BYTE 8'h00

`endif

// ---- hdl/dtc_pkg.sv ----
`default_nettype none
package dtc_pkg;
   typedef enum logic [1:0]
   {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;

   typedef struct packed
   {
      logic [7:0] hi;
      logic [7:0] lo;
      logic ovf;
   } dtc_step_t;

   typedef struct packed
   {
      logic [3:0] ph;
   } dtc_tick_st_t;

   typedef struct packed
   {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [1:0] smp;
      logic [1:0] pend;
   } dtc_edge_st_t;

   typedef struct packed
   {
      logic [7:0] timer_mode_register;
      logic tr0;
      logic tr1;
      logic tf0;
      logic tf1;
      logic [7:0] tl0;
      logic [7:0] th0;
      logic [7:0] tl1;
      logic [7:0] th1;
      logic dph_act;
      logic dph_wr;
      logic dph_ok;
      logic [7:0] dph_addr;
   } dtc_core_st_t;
endpackage
`default_nettype wire

// ---- hdl/dtc_tick_if.sv ----
`default_nettype none
interface dtc_tick_if;
   logic cnt_stb;
   logic smp_stb;
   logic [1:0] ev_fall;
   logic [1:0] gate_lvl;
   modport gen (output cnt_stb, output smp_stb);
   modport edge_det (input cnt_stb, input smp_stb, output ev_fall,
      output gate_lvl);
   modport core (input cnt_stb, input smp_stb, input ev_fall,
      input gate_lvl);
endinterface
`default_nettype wire

// ---- hdl/dtc_tick.sv ----
`include "dtc_cfg.svh"
`default_nettype none
module dtc_tick
(
   input wire logic sys_clk,
   input wire logic rst_n,
   dtc_tick_if.gen tif
);
   dtc_pkg::dtc_tick_st_t q;
   dtc_pkg::dtc_tick_st_t n;

   always_comb
   begin
      n = q;
      if (q.ph == `DTC_PH_LAST)
      begin
         n.ph = 4'h0;
      end
      else
      begin
         n.ph = q.ph + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign tif.cnt_stb = (q.ph == `DTC_PH_S3P1);
   assign tif.smp_stb = (q.ph == `DTC_PH_S5P2);
endmodule
`default_nettype wire

// ---- hdl/dtc_edge.sv ----
`include "dtc_cfg.svh"
`default_nettype none
module dtc_edge
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic event_pin_zero,
   input wire logic event_pin_one,
   input wire logic gating_input_zero,
   input wire logic gating_input_one,
   dtc_tick_if.edge_det tif
);
   dtc_pkg::dtc_edge_st_t q;
   dtc_pkg::dtc_edge_st_t n;

   always_comb
   begin
      n = q;
      n.s1 = {gating_input_one, gating_input_zero, event_pin_one,
         event_pin_zero};
      n.s2 = q.s1;
      // Pending edge is used up at the count strobe
      if (tif.cnt_stb)
      begin
         n.pend = 2'b00;
      end
      if (tif.smp_stb)
      begin
         n.smp = q.s2[1:0];
         n.pend = q.pend | (q.smp & ~q.s2[1:0]);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign tif.ev_fall = q.pend;
   assign tif.gate_lvl = q.s2[3:2];
endmodule
`default_nettype wire

// ---- hdl/dtc_top.sv ----
// The AHB-Lite slave port and the address map were decided locally.
`include "dtc_cfg.svh"
`default_nettype none
module dtc_top
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic event_pin_zero,
   input wire logic event_pin_one,
   input wire logic gating_input_zero,
   input wire logic gating_input_one,
   input wire logic vector_ack_zero,
   input wire logic vector_ack_one,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag
);
   logic [1:0] rst_sync_r;
   logic rst_n;
   dtc_pkg::dtc_core_st_t q;
   dtc_pkg::dtc_core_st_t n;
   dtc_pkg::dtc_step_t s0;
   dtc_pkg::dtc_step_t s1;
   logic [8:0] th0_inc;
   logic [1:0] md0;
   logic [1:0] md1;
   logic split;
   logic run0;
   logic run1;
   logic pulse0;
   logic pulse1;
   logic pulse_th0;
   logic set0;
   logic set1;
   logic tf0_base;
   logic tf1_base;
   logic wr_hit;

   dtc_tick_if tif();

   dtc_tick u_tick
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tif(tif)
   );

   dtc_edge u_edge
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .event_pin_zero(event_pin_zero),
      .event_pin_one(event_pin_one),
      .gating_input_zero(gating_input_zero),
      .gating_input_one(gating_input_one),
      .tif(tif)
   );

   // Reset release synchroniser
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_sync_r <= 2'b00;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
      dtc_inc8 = {1'b0, v} + 9'h001;
   endfunction

   // One count step of a timer pair in the given mode
   function automatic dtc_pkg::dtc_step_t dtc_step(input logic [1:0] md,
      input logic [7:0] hi, input logic [7:0] lo);
      logic [5:0] p;
      logic [16:0] w;
      logic [8:0] b;
      dtc_step = '0;
      p = {1'b0, lo[4:0]} + 6'h01;
      w = {1'b0, hi, lo} + 17'h00001;
      b = dtc_inc8(lo);
      dtc_step.hi = hi;
      dtc_step.lo = lo;
      unique case (md)
         dtc_pkg::DTC_MODE_13BIT:
         begin
            // Upper three low-byte bits are left alone
            dtc_step.lo = {lo[7:5], p[4:0]};
            if (p[5])
            begin
               dtc_step.hi = hi + 8'h01;
            end
            dtc_step.ovf = p[5] && (hi == 8'hff);
         end
         dtc_pkg::DTC_MODE_16BIT:
         begin
            dtc_step.hi = w[15:8];
            dtc_step.lo = w[7:0];
            dtc_step.ovf = w[16];
         end
         dtc_pkg::DTC_MODE_RELOAD:
         begin
            dtc_step.lo = b[8] ? hi : b[7:0];
            dtc_step.ovf = b[8];
         end
         dtc_pkg::DTC_MODE_SPLIT:
         begin
            dtc_step.lo = b[7:0];
            dtc_step.ovf = b[8];
         end
      endcase
   endfunction

   always_comb
   begin
      md0 = q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_MD0_LSB+1:`DTC_TIMER_MODE_REGISTER_MD0_LSB];
      md1 = q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_MD1_LSB+1:`DTC_TIMER_MODE_REGISTER_MD1_LSB];
      split = (md0 == dtc_pkg::DTC_MODE_SPLIT);
      run0 = q.tr0 && (!q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_GATE0] || tif.gate_lvl[0]);
      // Timer 1 loses its run bit to the split high byte
      run1 = (split || q.tr1) && (md1 != dtc_pkg::DTC_MODE_SPLIT) &&
         (!q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_GATE1] || tif.gate_lvl[1]);
      pulse0 = tif.cnt_stb && run0 &&
         (!q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_CT0] || tif.ev_fall[0]);
      pulse1 = tif.cnt_stb && run1 &&
         (!q.timer_mode_register[`DTC_TIMER_MODE_REGISTER_CT1] || tif.ev_fall[1]);
      pulse_th0 = tif.cnt_stb && split && q.tr1;
      s0 = dtc_step(md0, q.th0, q.tl0);
      s1 = dtc_step(md1, q.th1, q.tl1);
      th0_inc = dtc_inc8(q.th0);
      set0 = pulse0 && s0.ovf;
      set1 = (pulse1 && s1.ovf && !split) ||
         (pulse_th0 && th0_inc[8]);
   end

   always_comb
   begin
      n = q;
      // Count updates
      if (pulse0)
      begin
         n.tl0 = s0.lo;
         n.th0 = s0.hi;
      end
      if (pulse_th0)
      begin
         n.th0 = th0_inc[7:0];
      end
      if (pulse1)
      begin
         n.tl1 = s1.lo;
         n.th1 = s1.hi;
      end
      // Data phase write; overrides a count step in the same cycle
      tf0_base = q.tf0;
      tf1_base = q.tf1;
      wr_hit = q.dph_act && q.dph_wr && q.dph_ok;
      if (wr_hit)
      begin
         unique case (q.dph_addr)
            `DTC_OFF_MODE:
            begin
               n.timer_mode_register = hwdata[7:0];
            end
            `DTC_OFF_CTRL:
            begin
               // Run bits touch no count register
               n.tr0 = hwdata[`DTC_TIMER_CONTROL_REGISTER_TR0];
               n.tr1 = hwdata[`DTC_TIMER_CONTROL_REGISTER_TR1];
               tf0_base = hwdata[`DTC_TIMER_CONTROL_REGISTER_TF0];
               tf1_base = hwdata[`DTC_TIMER_CONTROL_REGISTER_TF1];
            end
            `DTC_OFF_T0LO:
            begin
               n.tl0 = hwdata[7:0];
            end
            `DTC_OFF_T0HI:
            begin
               n.th0 = hwdata[7:0];
            end
            `DTC_OFF_T1LO:
            begin
               n.tl1 = hwdata[7:0];
            end
            `DTC_OFF_T1HI:
            begin
               n.th1 = hwdata[7:0];
            end
            default:
            begin
               n.timer_mode_register = q.timer_mode_register;
            end
         endcase
      end
      // Hardware set beats software or acknowledge clear
      n.tf0 = (tf0_base && !vector_ack_zero) || set0;
      n.tf1 = (tf1_base && !vector_ack_one) || set1;
      // Address phase capture
      n.dph_act = hsel && htrans[1] && hready;
      n.dph_wr = hwrite;
      n.dph_addr = haddr[7:0];
      n.dph_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00) &&
         (haddr[7:0] <= `DTC_OFF_T1HI);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   // Read data straight from the register flops during the data phase
   always_comb
   begin
      hrdata = 32'h00000000;
      if (q.dph_act && !q.dph_wr && q.dph_ok)
      begin
         unique case (q.dph_addr)
            `DTC_OFF_MODE:
            begin
               hrdata = {24'h000000, q.timer_mode_register};
            end
            `DTC_OFF_CTRL:
            begin
               hrdata = {24'h000000, q.tf1, q.tr1, q.tf0, q.tr0, 4'h0};
            end
            `DTC_OFF_T0LO:
            begin
               hrdata = {24'h000000, q.tl0};
            end
            `DTC_OFF_T0HI:
            begin
               hrdata = {24'h000000, q.th0};
            end
            `DTC_OFF_T1LO:
            begin
               hrdata = {24'h000000, q.tl1};
            end
            `DTC_OFF_T1HI:
            begin
               hrdata = {24'h000000, q.th1};
            end
            default:
            begin
               hrdata = 32'h00000000;
            end
         endcase
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign timer0_overflow_flag = q.tf0;
   assign timer1_overflow_flag = q.tf1;
endmodule
`default_nettype wire

// ---- tb/dtc_pins_model.sv ----
`default_nettype none
module dtc_pins_model
(
   input wire logic sys_clk,
   output logic event_pin_zero,
   output logic event_pin_one,
   output logic gating_input_zero,
   output logic gating_input_one
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {event_pin_zero, event_pin_one} = 2'b11;
      {gating_input_zero, gating_input_one} = 2'b00;
   end
   // Toggles pin zero, each level held len cycles
   task automatic pulses(input int n, input int len);
      repeat (2 * n)
      begin
         event_pin_zero <= !event_pin_zero;
         repeat (len) @(posedge sys_clk);
      end
   endtask
   task automatic gate(input logic g0, input logic g1);
      gating_input_zero <= g0;
      gating_input_one <= g1;
   endtask
endmodule
`default_nettype wire

// ---- tb/dtc_checker.sv ----
`default_nettype none
module dtc_checker
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic vector_ack_zero,
   input wire logic vector_ack_one,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_r;
   logic rd_r;
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
         {wr_r, rd_r} <= 2'b00;
      else
         {wr_r, rd_r} <= {2{hsel & htrans[1] & hready}} & {hwrite, !hwrite};
   end
   bus_okay_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !hresp && hreadyout) else $error("bus answer wrong");
   rd_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rd_r |-> hrdata[31:8] == 24'h0) else $error("read upper bits");
   rst_clear_a: assert property (@(posedge sys_clk)
      !rst_b |-> !timer0_overflow_flag && !timer1_overflow_flag
      && hrdata == 32'h0) else $error("reset state");
   rst_release_a: assert property (@(posedge sys_clk)
      disable iff (!rst_b) $rose(rst_b) |->
      (!timer0_overflow_flag && !timer1_overflow_flag) [*3])
      else $error("flag after reset");
   ack0_clear_a: assert property (@(posedge sys_clk)
      disable iff (!rst_b) vector_ack_zero [*2] |->
      ##[0:1] !timer0_overflow_flag) else $error("flag 0 not cleared");
   ack1_clear_a: assert property (@(posedge sys_clk)
      disable iff (!rst_b) vector_ack_one [*2] |->
      ##[0:1] !timer1_overflow_flag) else $error("flag 1 not cleared");
   flag0_hold_a: assert property (@(posedge sys_clk)
      disable iff (!rst_b) timer0_overflow_flag && !vector_ack_zero
      && !wr_r |=> timer0_overflow_flag) else $error("flag 0 lost");
   flag1_hold_a: assert property (@(posedge sys_clk)
      disable iff (!rst_b) timer1_overflow_flag && !vector_ack_one
      && !wr_r |=> timer1_overflow_flag) else $error("flag 1 lost");
endmodule
bind dtc_top dtc_checker u_chk (.sys_clk, .rst_b, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .vector_ack_zero,
   .vector_ack_one, .timer0_overflow_flag, .timer1_overflow_flag);
`default_nettype wire

// ---- tb/dtc_top_tb.sv ----
`include "dtc_cfg.svh"
`default_nettype none
module dtc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] ack = 2'b00;
   logic rd_dp = 1'b0;
   logic hready, hresp, f0, f1, ev0, ev1, g0, g1;
   logic [31:0] hrdata;
   logic [31:0] seed = 32'h6e47b6ac;
   logic [7:0] exp_q[$];
   logic [7:0] h, l, eh, el, k, fl;
   logic [15:0] v;
   logic [39:0] cases [3] = '{40'hfffe00e103, 40'hfffe000103,
      40'h80fe808204};
   int failures = 0;
   int n_checks = 0;
   dtc_top u_dut (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
      .event_pin_zero(ev0), .event_pin_one(ev1), .gating_input_zero(g0),
      .gating_input_one(g1), .vector_ack_zero(ack[0]),
      .vector_ack_one(ack[1]), .timer0_overflow_flag(f0),
      .timer1_overflow_flag(f1));
   dtc_pins_model u_pins (.sys_clk, .event_pin_zero(ev0),
      .event_pin_one(ev1), .gating_input_zero(g0), .gating_input_one(g1));
   initial
      forever #4 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(input string what, input logic [7:0] e,
      input logic [7:0] s);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic waitrdy();
      @(posedge sys_clk);
      while (hready !== 1'b1)
         @(posedge sys_clk);
   endtask
   task automatic aph(input logic [7:0] a, input logic w);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      waitrdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      aph(a, 1'b1);
      hwdata <= {24'h0, d};
      waitrdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      aph(a, 1'b0);
      waitrdy();
   endtask
   // Exactly k machine cycles of enable; flags captured before the stop
   task automatic run(input logic [7:0] c, input int k);
      wr(`DTC_OFF_CTRL, c);
      repeat (12 * k - 2) @(posedge sys_clk);
      fl = {6'h0, f1, f0};
      wr(`DTC_OFF_CTRL, 8'h00);
   endtask
   always @(posedge sys_clk)
   begin
      if (rd_dp === 1'b1)
         cmp("hrdata", exp_q.pop_front(), hrdata[7:0]);
      rd_dp <= hsel & htrans[1] & hready & !hwrite;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      give_verdict();
   end
   initial
   begin
      #1 rst_b = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 7; i++)
         rd(8'(4 * i), 8'h00);
      wr(8'h18, 8'hff);
      rd(8'h18, 8'h00);
      for (int t = 0; t < 2; t++)
         for (int m = 0; m < 3; m++)
         begin
            {h, l, eh, el, k} = cases[m];
            wr(`DTC_OFF_MODE, 8'(m << (4 * t)));
            wr(`DTC_OFF_T0HI + 8'(8 * t), h);
            wr(`DTC_OFF_T0LO + 8'(8 * t), l);
            run(8'(8'h10 << (2 * t)), int'(k));
            cmp("flags", 8'(1 << t), fl);
            rd(`DTC_OFF_T0LO + 8'(8 * t), el);
            rd(`DTC_OFF_T0HI + 8'(8 * t), eh);
         end
      wr(`DTC_OFF_MODE, 8'h05);
      wr(`DTC_OFF_T0LO, 8'h00);
      wr(`DTC_OFF_T0HI, 8'h00);
      wr(`DTC_OFF_CTRL, 8'h10);
      u_pins.pulses(5, 12);
      repeat (36) @(posedge sys_clk);
      wr(`DTC_OFF_CTRL, 8'h00);
      rd(`DTC_OFF_T0LO, 8'h05);
      v = 16'(rnd());
      wr(`DTC_OFF_MODE, 8'h90);
      wr(`DTC_OFF_T1LO, v[7:0]);
      wr(`DTC_OFF_T1HI, v[15:8]);
      run(8'h40, 2);
      rd(`DTC_OFF_T1LO, v[7:0]);
      u_pins.gate(1'b0, 1'b1);
      repeat (4) @(posedge sys_clk);
      run(8'h40, 2);
      v = v + 16'h2;
      rd(`DTC_OFF_T1LO, v[7:0]);
      rd(`DTC_OFF_T1HI, v[15:8]);
      wr(`DTC_OFF_MODE, 8'h33);
      wr(`DTC_OFF_T0LO, 8'hff);
      wr(`DTC_OFF_T0HI, 8'hff);
      wr(`DTC_OFF_T1LO, 8'h55);
      run(8'h50, 2);
      cmp("flags", 8'h03, fl);
      rd(`DTC_OFF_T0LO, 8'h01);
      rd(`DTC_OFF_T0HI, 8'h01);
      rd(`DTC_OFF_T1LO, 8'h55);
      wr(`DTC_OFF_CTRL, 8'ha0);
      rd(`DTC_OFF_CTRL, 8'ha0);
      ack <= 2'b11;
      repeat (2) @(posedge sys_clk);
      ack <= 2'b00;
      rd(`DTC_OFF_CTRL, 8'h00);
      repeat (2) @(posedge sys_clk);
      failures += exp_q.size();
      give_verdict();
   end
endmodule
`default_nettype wire
